// [udic_map.svh]
`ifndef UDIC_MAP_SVH
`define UDIC_MAP_SVH
// Register offsets
`define UDIC_OFS_DIV_LOW      3'h0
`define UDIC_OFS_DIV_HIGH     3'h1
`define UDIC_OFS_IRQ_MASK     3'h1
`define UDIC_OFS_FIFO_CTRL    3'h2
`define UDIC_OFS_PEND_CODE    3'h2
// Field positions
`define UDIC_BIT_BAUD_SEL     7
`define UDIC_BIT_MODEM_EN     3
`define UDIC_BIT_LINE_EN      2
`define UDIC_BIT_THRE_EN      1
`define UDIC_BIT_RX_REQUEST_PIN_EN     0
`define UDIC_BIT_DMA_SEL      3
`define UDIC_BIT_TX_FLUSH     2
`define UDIC_BIT_RX_FLUSH     1
`define UDIC_BIT_Q_EN         0
`define UDIC_IRQ_EN_MASK      8'h0F
// Reset values
`define UDIC_RST_DIV_LOW      8'h00
`define UDIC_RST_DIV_HIGH     8'h00
`define UDIC_RST_IRQ_MASK     8'h00
`define UDIC_RST_FIFO_CTRL    8'h00
// Receive thresholds in bytes
`define UDIC_THR_0            5'h01
`define UDIC_THR_1            5'h04
`define UDIC_THR_2            5'h08
`define UDIC_THR_3            5'h0E
// Identification codes, bits 3:0
`define UDIC_ID_NONE          4'h1
`define UDIC_ID_LINE          4'h6
`define UDIC_ID_RXDATA        4'h4
`define UDIC_ID_TIMEOUT       4'hC
`define UDIC_ID_THRE          4'h2
`define UDIC_ID_MODEM         4'h0
`endif

// [udic_pkg.sv]
package udic_pkg;
   // Interrupt sources as seen by the priority logic
   typedef struct packed {
      logic line_err;
      logic rx_data;
      logic rx_timeout;
      logic thre;
      logic modem;
   } udic_src_type;
   // Flush and mode strobes toward the queues
   typedef struct packed {
      logic tx_flush;
      logic rx_flush;
      logic enable;
   } udic_queue_type;
   typedef enum logic [1:0] {
      UDIC_THR_1B,
      UDIC_THR_4B,
      UDIC_THR_8B,
      UDIC_THR_14B
   } udic_thr_type;
endpackage : udic_pkg

// [udic_ctrl.sv]
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Divisor low byte at offset 0 when divisor latch set, RW, resets zero.
// - Divisor upper seven bits at offset 1 bits 6:0 when latch set, RW.
// - Clock source low: divisor-high bit 7 picks slow (0) or fast (1) base.
// - Clock source high: baud select bit is ignored.
// - Mask bit 3 enables modem status change interrupt.
// - Mask bit 2 enables receive line error interrupt.
// - Mask bit 1 enables transmit holding empty interrupt.
// - Mask bit 0 enables receive data and, in queue mode, timeout interrupt.
// - All mask bits clear suppresses interrupt output and identification.
// - Queue control is write-only at 02h; reads return identification.
// - Control bit 3 accepted but has no effect.
// - Control bit 2 flushes transmit queue; self-clearing.
// - Control bit 1 flushes receive queue; self-clearing.
// - Control bit 0 enables queues; zero disables and discards them.
// - Leaving queue mode flushes both queues.
// - Other control bits take effect only when bit 0 set in same write.
// - Bits 7:6 set receive threshold 1, 4, 8 or 14 bytes.
// - Four priority levels: line status highest, receive data second.
// - Transmit holding empty third, modem status fourth and lowest.
// - In queue mode a timeout shows bit 3 together with bit 2.
module udic_ctrl
   import udic_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [2:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output      logic [7:0]  RDATA,
   input  wire logic        DIV_LATCH,
   input  wire logic        CLOCK_SOURCE_SELECT_SEL,
   input  wire udic_src_type SRC,
   output      logic [14:0] DIVISOR,
   output      logic        BAUD_FAST,
   output      logic        Q_ENABLE,
   output      logic        TX_FLUSH,
   output      logic        RX_FLUSH,
   output      logic [4:0]  RX_THRESHOLD,
   output      logic        IRQ
);
`include "udic_map.svh"

   logic [7:0]     div_low_reg;
   logic [7:0]     div_high_reg;
   logic [3:0]     irq_mask_reg;
   logic           q_en_reg;
   logic           dma_sel_reg;
   udic_thr_type   thr_reg;
   udic_queue_type flush_reg;
   logic [7:0]     rdata_reg;
   logic           latch_s2_reg;
   logic           src_s2_reg;
   udic_src_type   src_s2_q;
   logic [6:0]     sync_in;
   logic           sync_s1_reg [7];
   logic           sync_s2_reg [7];
   udic_thr_type   thr_sel;
   logic [4:0]     thr_bytes;
   logic [4:0]     rx_thr_reg;
   logic           wr_div_low, wr_div_high, wr_mask, wr_fifo;
   logic [3:0]     pend_code;
   logic [7:0]     id_byte;
   logic           q_en_next;

   // Latch, clock source and the five sources arrive from other logic
   // that may run on another clock; every bit passes two flops so that
   // a metastable level never reaches the decode or the priority logic
   assign sync_in = {DIV_LATCH, CLOCK_SOURCE_SELECT_SEL, SRC};

   // One two-flop chain per bit; only the second flop is read
   for (genvar g = 0; g < 7; g++) begin : gen_sync
      always_ff @(posedge CLK or negedge NRST) begin
         if (!NRST) begin
            sync_s1_reg[g] <= 1'b0;
            sync_s2_reg[g] <= 1'b0;
         end else begin
            sync_s1_reg[g] <= sync_in[g];
            sync_s2_reg[g] <= sync_s1_reg[g];
         end
      end
   end

   // Synchronised views; bit order follows the source struct
   assign latch_s2_reg = sync_s2_reg[6];
   assign src_s2_reg   = sync_s2_reg[5];
   assign src_s2_q     = {sync_s2_reg[4], sync_s2_reg[3], sync_s2_reg[2],
                          sync_s2_reg[1], sync_s2_reg[0]};

   // Write decode; the divisor latch steers offsets 0 and 1
   assign wr_div_low  = WR && ADDR == `UDIC_OFS_DIV_LOW && latch_s2_reg;
   assign wr_div_high = WR && ADDR == `UDIC_OFS_DIV_HIGH && latch_s2_reg;
   assign wr_mask     = WR && ADDR == `UDIC_OFS_IRQ_MASK && !latch_s2_reg;
   assign wr_fifo     = WR && ADDR == `UDIC_OFS_FIFO_CTRL;

   // Divisor bytes including the baud base select in bit 7
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         div_low_reg  <= `UDIC_RST_DIV_LOW;
         div_high_reg <= `UDIC_RST_DIV_HIGH;
      end else begin
         if (wr_div_low)
            div_low_reg <= WDATA;
         if (wr_div_high)
            div_high_reg <= WDATA;
      end
   end

   assign DIVISOR   = {div_high_reg[6:0], div_low_reg};
   // External clock source overrides the select bit
   assign BAUD_FAST = !src_s2_reg && div_high_reg[`UDIC_BIT_BAUD_SEL];

   // Interrupt mask; upper nibble is not stored at all
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST)
         irq_mask_reg <= 4'(`UDIC_RST_IRQ_MASK & `UDIC_IRQ_EN_MASK);
      else if (wr_mask)
         irq_mask_reg <= WDATA[3:0];
   end

   // Bit 0 is always taken; the queue enable itself lives in flush_reg
   assign q_en_next = WDATA[`UDIC_BIT_Q_EN];
   assign q_en_reg  = flush_reg.enable;
   assign thr_sel   = udic_thr_type'(WDATA[7:6]);

   // Other fields only land when bit 0 is set in the same write
   // The mode select bit is stored but drives nothing: no request pins
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dma_sel_reg <= 1'b0;
         thr_reg     <= UDIC_THR_1B;
         rx_thr_reg  <= `UDIC_THR_0;
      end else if (wr_fifo && q_en_next) begin
         dma_sel_reg <= WDATA[`UDIC_BIT_DMA_SEL];
         thr_reg     <= thr_sel;
         rx_thr_reg  <= thr_bytes;
      end
   end

   // Flush strobes last one cycle; leaving queue mode flushes both
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST)
         flush_reg <= '0;
      else begin
         flush_reg.enable   <= wr_fifo ? q_en_next : flush_reg.enable;
         flush_reg.tx_flush <= wr_fifo && ((q_en_next && WDATA[`UDIC_BIT_TX_FLUSH])
                               || !q_en_next);
         flush_reg.rx_flush <= wr_fifo && ((q_en_next && WDATA[`UDIC_BIT_RX_FLUSH])
                               || !q_en_next);
      end
   end

   assign Q_ENABLE = q_en_reg;
   assign TX_FLUSH = flush_reg.tx_flush;
   assign RX_FLUSH = flush_reg.rx_flush;

   // Threshold decode of the written field, ahead of the holding flop
   always_comb begin
      unique case (thr_sel)
         UDIC_THR_1B:  thr_bytes = `UDIC_THR_0;
         UDIC_THR_4B:  thr_bytes = `UDIC_THR_1;
         UDIC_THR_8B:  thr_bytes = `UDIC_THR_2;
         UDIC_THR_14B: thr_bytes = `UDIC_THR_3;
      endcase
   end

   // Byte count comes from a flop so the output never glitches
   assign RX_THRESHOLD = rx_thr_reg;

   // Priority encoder; masked sources never reach the code
   always_comb begin
      if (src_s2_q.line_err && irq_mask_reg[`UDIC_BIT_LINE_EN])
         pend_code = `UDIC_ID_LINE;
      else if (src_s2_q.rx_data && irq_mask_reg[`UDIC_BIT_RX_REQUEST_PIN_EN])
         pend_code = `UDIC_ID_RXDATA;
      else if (src_s2_q.rx_timeout && q_en_reg && irq_mask_reg[`UDIC_BIT_RX_REQUEST_PIN_EN])
         pend_code = `UDIC_ID_TIMEOUT;
      else if (src_s2_q.thre && irq_mask_reg[`UDIC_BIT_THRE_EN])
         pend_code = `UDIC_ID_THRE;
      else if (src_s2_q.modem && irq_mask_reg[`UDIC_BIT_MODEM_EN])
         pend_code = `UDIC_ID_MODEM;
      else
         pend_code = `UDIC_ID_NONE;
   end

   assign id_byte = {{2{q_en_reg}}, 2'b00, pend_code};

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST)
         rdata_reg <= 8'h00;
      else if (RD) begin
         unique case (ADDR)
            `UDIC_OFS_DIV_LOW:  rdata_reg <= latch_s2_reg ? div_low_reg : 8'h00;
            `UDIC_OFS_DIV_HIGH: rdata_reg <= latch_s2_reg ? div_high_reg
                                             : {4'h0, irq_mask_reg};
            `UDIC_OFS_PEND_CODE: rdata_reg <= id_byte;
            default:            rdata_reg <= 8'h00;
         endcase
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ   = pend_code[0] == 1'b0;

   // Checks below watch only what this block drives; they are all on the
   // core clock and are switched off while reset is low, so the first
   // edge after release compares against reset values only

   // A divisor low write shows on the output one cycle later
   chk_div_write: assert property (@(posedge CLK) disable iff (!NRST)
      wr_div_low |=> DIVISOR[7:0] == $past(WDATA))
      else $error("divisor low not written");

   // Without a low-byte write the low byte holds
   chk_div_low_hold: assert property (@(posedge CLK) disable iff (!NRST)
      !wr_div_low |=> $stable(DIVISOR[7:0]))
      else $error("divisor low changed without write");

   // Upper divisor bits follow bits 6:0 of the written byte
   chk_div_high: assert property (@(posedge CLK) disable iff (!NRST)
      wr_div_high |=> DIVISOR[14:8] == $past(WDATA[6:0]))
      else $error("divisor high not written");

   // Without a high-byte write the upper bits hold
   chk_div_high_hold: assert property (@(posedge CLK) disable iff (!NRST)
      !wr_div_high |=> $stable(DIVISOR[14:8]))
      else $error("divisor high changed without write");

   // With the internal source, the stored select bit picks the base
   chk_baud_sel: assert property (@(posedge CLK) disable iff (!NRST)
      !src_s2_reg |-> BAUD_FAST == div_high_reg[`UDIC_BIT_BAUD_SEL])
      else $error("baud base not from select bit");

   // With the external source, the select bit has no say
   chk_baud_src: assert property (@(posedge CLK) disable iff (!NRST)
      src_s2_reg |-> !BAUD_FAST)
      else $error("baud select not ignored");

   // A masked modem change never becomes the pending code
   chk_modem_en: assert property (@(posedge CLK) disable iff (!NRST)
      !irq_mask_reg[`UDIC_BIT_MODEM_EN] |-> pend_code != `UDIC_ID_MODEM)
      else $error("modem interrupt while disabled");

   // A masked line error never becomes the pending code
   chk_line_en: assert property (@(posedge CLK) disable iff (!NRST)
      !irq_mask_reg[`UDIC_BIT_LINE_EN] |-> pend_code != `UDIC_ID_LINE)
      else $error("line interrupt while disabled");

   // A masked holding-empty never becomes the pending code
   chk_thre_en: assert property (@(posedge CLK) disable iff (!NRST)
      !irq_mask_reg[`UDIC_BIT_THRE_EN] |-> pend_code != `UDIC_ID_THRE)
      else $error("holding empty interrupt while disabled");

   // Bit 0 gates both receive data and the timeout
   chk_rx_en: assert property (@(posedge CLK) disable iff (!NRST)
      !irq_mask_reg[`UDIC_BIT_RX_REQUEST_PIN_EN] |->
      pend_code != `UDIC_ID_RXDATA && pend_code != `UDIC_ID_TIMEOUT)
      else $error("receive interrupt while disabled");

   // An all-clear mask keeps the interrupt line quiet
   chk_irq_none: assert property (@(posedge CLK) disable iff (!NRST)
      irq_mask_reg == 4'h0 |-> !IRQ)
      else $error("interrupt with mask clear");

   // The offset 02h read always returns the identification byte
   chk_read_id: assert property (@(posedge CLK) disable iff (!NRST)
      RD && ADDR == `UDIC_OFS_PEND_CODE |=> RDATA == $past(id_byte))
      else $error("identification read wrong");

   // Transmit flush only ever follows a control write
   chk_flush_pulse: assert property (@(posedge CLK) disable iff (!NRST)
      TX_FLUSH && !$past(wr_fifo) |-> 1'b0)
      else $error("transmit flush not from write");

   // Requested transmit flush fires the cycle after the write
   chk_tx_flush_set: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo && WDATA[`UDIC_BIT_Q_EN] && WDATA[`UDIC_BIT_TX_FLUSH] |=> TX_FLUSH)
      else $error("transmit flush missing");

   // Flush strobes clear themselves when no write is taken
   chk_flush_clear: assert property (@(posedge CLK) disable iff (!NRST)
      !wr_fifo |=> !TX_FLUSH && !RX_FLUSH)
      else $error("flush strobe not self-clearing");

   // Requested receive flush fires the cycle after the write
   chk_rx_flush_set: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo && WDATA[`UDIC_BIT_Q_EN] && WDATA[`UDIC_BIT_RX_FLUSH] |=> RX_FLUSH)
      else $error("receive flush missing");

   // Receive flush only ever follows a control write
   chk_rx_flush_src: assert property (@(posedge CLK) disable iff (!NRST)
      RX_FLUSH |-> $past(wr_fifo))
      else $error("receive flush not from write");

   // Queue mode follows bit 0 of every control write
   chk_q_enable: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo |=> Q_ENABLE == $past(WDATA[`UDIC_BIT_Q_EN]))
      else $error("queue enable not written");

   // Leaving queue mode flushes both queues
   chk_leave_flush: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo && !WDATA[0] |=> RX_FLUSH && TX_FLUSH && !Q_ENABLE)
      else $error("queues not flushed on disable");

   // A write with bit 0 low leaves the threshold alone
   chk_thr_keep: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo && !WDATA[0] |=> $stable(RX_THRESHOLD))
      else $error("threshold changed without enable");

   // Top threshold code gives fourteen bytes
   chk_thr_top: assert property (@(posedge CLK) disable iff (!NRST)
      wr_fifo && WDATA[`UDIC_BIT_Q_EN] && WDATA[7:6] == 2'b11 |=>
      RX_THRESHOLD == `UDIC_THR_3)
      else $error("top threshold wrong");

   // An enabled line error outranks everything
   chk_line_first: assert property (@(posedge CLK) disable iff (!NRST)
      src_s2_q.line_err && irq_mask_reg[2] |-> pend_code == `UDIC_ID_LINE)
      else $error("line status not highest");

   // Receive data is second, below an enabled line error only
   chk_rx_second: assert property (@(posedge CLK) disable iff (!NRST)
      src_s2_q.rx_data && irq_mask_reg[`UDIC_BIT_RX_REQUEST_PIN_EN] &&
      !(src_s2_q.line_err && irq_mask_reg[`UDIC_BIT_LINE_EN]) |->
      pend_code == `UDIC_ID_RXDATA)
      else $error("receive data not second");

   // Modem status never wins over an enabled holding-empty
   chk_modem_last: assert property (@(posedge CLK) disable iff (!NRST)
      pend_code == `UDIC_ID_MODEM |->
      !(src_s2_q.thre && irq_mask_reg[`UDIC_BIT_THRE_EN]))
      else $error("modem status not lowest");

   // The timeout code only appears in queue mode
   chk_timeout_mode: assert property (@(posedge CLK) disable iff (!NRST)
      pend_code == `UDIC_ID_TIMEOUT |-> Q_ENABLE)
      else $error("timeout outside queue mode");

   // Writes with the latch set never reach the mask
   chk_mask_steer: assert property (@(posedge CLK) disable iff (!NRST)
      WR && latch_s2_reg |=> $stable(irq_mask_reg))
      else $error("mask written through divisor window");

   // Writes with the latch clear never reach the divisor
   chk_div_steer: assert property (@(posedge CLK) disable iff (!NRST)
      WR && !latch_s2_reg |=> $stable(DIVISOR))
      else $error("divisor written through mask window");

   // Reserved mask bits read back as zero
   chk_mask_upper: assert property (@(posedge CLK) disable iff (!NRST)
      RD && ADDR == `UDIC_OFS_IRQ_MASK && !latch_s2_reg |=> RDATA[7:4] == 4'h0)
      else $error("reserved mask bits nonzero");

   // Main scenarios worth seeing at least once
   cov_timeout: cover property (@(posedge CLK) disable iff (!NRST)
      pend_code == `UDIC_ID_TIMEOUT);
   cov_rx_flush: cover property (@(posedge CLK) disable iff (!NRST) RX_FLUSH && Q_ENABLE);
   cov_fast: cover property (@(posedge CLK) disable iff (!NRST) BAUD_FAST);
   cov_modem: cover property (@(posedge CLK) disable iff (!NRST) IRQ && pend_code == 4'h0);
   cov_thr_top: cover property (@(posedge CLK) disable iff (!NRST)
      thr_reg == UDIC_THR_14B);
endmodule : udic_ctrl

// [udic_line_model.sv]
`timescale 1ns/1ps
// Far-side stand-in: raises the line and modem conditions as levels
module udic_line_model
   import udic_pkg::*;
(
   input  wire logic         CLK,
   input  wire logic [4:0]   EVENTS,
   output      udic_src_type SRC
);
   // Conditions move just after an edge, never mid-cycle
   always_ff @(posedge CLK) begin
      SRC <= udic_src_type'(EVENTS);
   end
endmodule : udic_line_model

// [uart_divisor_irq_fifo_ctrl_bench.sv]
`timescale 1ns/1ps
module uart_divisor_irq_fifo_ctrl_bench;
   logic                 clk, nrst, wr, rd, latch, csel, rd_q;
   logic                 fast, qen, txf, rxf, irq;
   logic [2:0]           addr;
   logic [7:0]           wdata, rdata;
   logic [4:0]           ev, thr;
   logic [14:0]          divisor;
   logic [31:0]          seed;
   logic [7:0]           exp_q[$];
   udic_pkg::udic_src_type src;
   int                   num_errors, checks_done;
   logic [4:0] tt[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
   logic [4:0] pv[5] = '{5'h1F, 5'h0B, 5'h07, 5'h03, 5'h01};
   logic [3:0] pc[5] = '{4'h6, 4'h4, 4'hC, 4'h2, 4'h0};
   logic [4:0] mv[4] = '{5'h08, 5'h02, 5'h10, 5'h01};

   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end

   udic_ctrl udic_ctrl_i (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .DIV_LATCH(latch), .CLOCK_SOURCE_SELECT_SEL(csel), .SRC(src),
      .DIVISOR(divisor), .BAUD_FAST(fast), .Q_ENABLE(qen), .TX_FLUSH(txf),
      .RX_FLUSH(rxf), .RX_THRESHOLD(thr), .IRQ(irq));
   udic_line_model udic_line_model_i (.CLK(clk), .EVENTS(ev), .SRC(src));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task final_report;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // One-cycle bus strobes; read answers are queued for the monitor
   task automatic wrb(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrb

   task automatic rdb(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rdb

   // Inputs pass two sync stages plus the model register, so settle first
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Read data lands the cycle after the strobe and holds until the next read: sample it mid-cycle
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) begin
      if (rd_q && exp_q.size() == 0) begin
         num_errors++;
         $display("[ERR] rdata exp none got %h", rdata);
      end else if (rd_q)
         chk("rdata", exp_q.pop_front(), rdata);
   end

   // Watchdog cuts a hang short
   initial begin
      cyc(20000);
      num_errors++;
      final_report;
   end

   initial begin
      {nrst, wr, rd, addr, wdata, csel, ev} = '0;
      latch = 1'b1;
      seed = 32'h8467D245;
      cyc(3);
      nrst <= 1'b1;
      cyc(3);
      rdb(3'h0, 8'h00);
      rdb(3'h1, 8'h00);
      rdb(3'h2, 8'h01);
      #1 chk("thr", 16'h0001, 16'(thr));
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         wrb(3'h0, seed[7:0]);
         wrb(3'h1, seed[15:8]);
         #1 chk("divisor", 16'({seed[14:8], seed[7:0]}), 16'(divisor));
         chk("fast", 16'(seed[15]), 16'(fast));
         rdb(3'h0, seed[7:0]);
         rdb(3'h1, seed[15:8]);
      end
      wrb(3'h1, 8'h80);
      csel <= 1'b1;
      cyc(3);
      #1 chk("fast", 16'h0000, 16'(fast));
      csel <= 1'b0;
      cyc(3);
      #1 chk("fast", 16'h0001, 16'(fast));
      $display("divisor test done");
      wrb(3'h5, 8'hA5);
      rdb(3'h5, 8'h00);
      latch <= 1'b0;
      cyc(3);
      rdb(3'h0, 8'h00);
      wrb(3'h1, 8'hFF);
      rdb(3'h1, 8'h0F);
      #1 chk("divisor", 16'({7'h00, seed[7:0]}), 16'(divisor));
      for (int k = 0; k < 4; k++) begin
         wrb(3'h2, {k[1:0], 6'b001111});
         #1 chk("qen", 16'h0001, 16'(qen));
         chk("flush", 16'h0003, 16'({txf, rxf}));
         chk("thr", 16'(tt[k]), 16'(thr));
         @(posedge clk);
         #1 chk("flush", 16'h0000, 16'({txf, rxf}));
      end
      rdb(3'h2, 8'hC1);
      for (int i = 0; i < 5; i++) begin
         ev <= pv[i];
         cyc(4);
         rdb(3'h2, {4'hC, pc[i]});
      end
      $display("priority test done");
      for (int i = 0; i < 4; i++) begin
         ev <= mv[i];
         wrb(3'h1, 8'h0F ^ 8'(1 << i));
         cyc(4);
         #1 chk("irq", 16'h0000, 16'(irq));
         wrb(3'h1, 8'(1 << i));
         #1 chk("irq", 16'h0001, 16'(irq));
      end
      ev <= 5'h04;
      cyc(4);
      #1 chk("irq", 16'h0000, 16'(irq));
      wrb(3'h1, 8'h01);
      #1 chk("irq", 16'h0001, 16'(irq));
      ev <= 5'h1F;
      wrb(3'h1, 8'h00);
      cyc(4);
      #1 chk("irq", 16'h0000, 16'(irq));
      rdb(3'h2, 8'hC1);
      wrb(3'h2, 8'h00);
      #1 chk("qen", 16'h0000, 16'(qen));
      chk("flush", 16'h0003, 16'({txf, rxf}));
      rdb(3'h2, 8'h01);
      // Timeout alone must stay silent outside queue mode
      ev <= 5'h04;
      wrb(3'h1, 8'h01);
      cyc(4);
      #1 chk("irq", 16'h0000, 16'(irq));
      rdb(3'h2, 8'h01);
      $display("queue control test done");
      // Mid-run reset: every register returns to its reset value
      @(posedge clk);
      nrst <= 1'b0;
      cyc(3);
      #1 chk("divisor", 16'h0000, 16'(divisor));
      chk("thr", 16'h0001, 16'(thr));
      chk("qen", 16'h0000, 16'(qen));
      @(posedge clk);
      nrst <= 1'b1;
      cyc(3);
      rdb(3'h1, 8'h00);
      rdb(3'h2, 8'h01);
      $display("reset test done");
      cyc(3);
      final_report;
   end
endmodule : uart_divisor_irq_fifo_ctrl_bench
